// ### pkg/iesrs_pkg.sv
// Purpose: shared constants and types of the serial eeprom slave with rf status pin
// Assumes: core clock of 125 MHz samples every pin; rf side logic runs on the same clock
// Notes:   byte array seen as 2048 x 8 from the serial side and 512 x 32 from the rf side
package iesrs_pkg;

  // memory geometry
  localparam int unsigned MEM_BYTES  = 2048;                 // serial view, bytes
  localparam int unsigned RF_WORDS   = 512;                  // rf view, 32-bit words
  localparam int unsigned BYTE_AW    = 11;                   // byte address width
  localparam int unsigned WORD_AW    = 9;                    // word address width
  localparam int unsigned WORD_BYTES = 4;                    // bytes per rf word

  // serial framing
  localparam logic [3:0] LAST_BIT  = 4'h7;                   // eighth data bit index
  localparam logic [3:0] ACK_BIT   = 4'h8;                   // ninth bit, acknowledge slot
  localparam logic [1:0] SEL_FIXED = 2'h3;                   // select byte bits 2..1
  localparam int unsigned SEL_TYPE_MSB = 7;                  // device type field top bit
  localparam int unsigned SEL_TYPE_LSB = 4;                  // device type field low bit
  localparam int unsigned SEL_CE_BIT   = 3;                  // internal chip enable bit
  localparam int unsigned SEL_RW_BIT   = 0;                  // direction bit, 1 = read
  localparam int unsigned HI_ADDR_BITS = 3;                  // used bits of the high address byte

  // buffering and synchronisers
  localparam int unsigned BUF_DEPTH = 2;                     // write buffer entries
  localparam int unsigned SYNC_W    = 6;                     // synchronised pin count
  localparam logic [5:0]  SYNC_RST  = 6'h03;                 // scl and sda idle high

  // serial slave states
  typedef enum logic [2:0] {
    IESRS_IDLE    = 3'h0,
    IESRS_DEV     = 3'h1,
    IESRS_ADDR_HI = 3'h2,
    IESRS_ADDR_LO = 3'h3,
    IESRS_WRITE   = 3'h4,
    IESRS_READ    = 3'h5
  } iesrs_state_t;

  // status pin behaviour
  typedef enum logic {
    IESRS_MODE_WRITE = 1'h0,                                 // rf internal write indicator
    IESRS_MODE_CMD   = 1'h1                                  // rf command indicator
  } iesrs_mode_t;

  // one byte written from the serial side
  typedef struct packed {
    logic [BYTE_AW-1:0] addr;
    logic [7:0]         data;
  } iesrs_wr_t;

  // word access from the rf side
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [WORD_AW-1:0] addr;
    logic [31:0]        wdata;
  } iesrs_rf_req_t;

endpackage

// ### logic/iesrs_buf.sv
// Purpose: small valid/ready buffer between the serial receiver and the array
// Assumes: DEPTH is a power of two, at least 2
// Notes:   full and empty are exact; ready low really stalls the filling side
module iesrs_buf #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];   // entries
  logic [PW-1:0]    wr_ptr;          // next slot to fill
  logic [PW-1:0]    rd_ptr;          // oldest entry
  logic [PW:0]      count;           // occupancy
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // entry storage, no reset needed since count guards it
  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // iesrs_buf

// ### logic/iesrs_top.sv
// Purpose: two-wire serial slave front end of a dual-interface eeprom, plus rf status pin
// Assumes: pins sampled by clk_i; rf request port is on clk_i; scl far slower than clk_i
// Notes:   serial writes queue through a two-entry buffer; rf word access wins the array port

// Functional notes
// - 2048 bytes serially, 512 words from rf
// - slave only, steps on master scl edges
// - start, select byte, then device acknowledge
// - device acknowledges each written byte, ninth bit; nack when the buffer is full
// - stop after ack on write, nack on read
// - status pin mode: write or command indicator
// - write mode: low during rf internal write
// - command mode: low during rf command
// - status pin open drain, low or released
// - status pin active only with supply present
// - select byte msb first, fixed bits, chip enable
module iesrs_top #(
  parameter logic [3:0] DEV_TYPE = 4'h5,                     // arbitrary device type code
  parameter logic       CHIP_EN  = 1'h0                      // internal chip enable value
) (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  input  wire logic                    vcc_ok_i,
  input  wire logic                    rf_mode_i,
  input  wire logic                    rf_write_busy_i,
  input  wire logic                    rf_cmd_busy_i,
  output logic                         rf_activity_output_o,
  output logic                         rf_activity_output_oe_o,
  input  iesrs_pkg::iesrs_rf_req_t     rf_req_i,
  output logic [31:0]                  rf_rdata_o,
  output logic                         rf_rvalid_o
);
  import iesrs_pkg::*;

  logic [7:0]          mem [MEM_BYTES];      // the shared array
  logic [SYNC_W-1:0]   sync1;                // first stage, read only by sync2
  logic [SYNC_W-1:0]   sync2;                // settled pin levels
  logic                scl_s, sda_s;         // settled bus lines
  logic                scl_d, sda_d;         // previous settled bus lines
  logic                vcc_s, mode_s;        // settled supply and mode
  logic                wr_busy_s, cmd_busy_s;
  logic                scl_rise, scl_fall;
  logic                start_c, stop_c;
  iesrs_state_t        state;
  logic [3:0]          bit_cnt;              // 0..7 data, 8 acknowledge
  logic [7:0]          shift_in;             // bits from master
  logic [7:0]          rd_shift;             // bits toward master
  logic [BYTE_AW-1:0]  addr;                 // serial byte pointer
  logic                rw;                   // direction of current select
  logic                ack_drv;              // device holds sda low for ack
  logic                master_ack;           // master acked last read byte
  logic                dev_match;
  logic [BYTE_AW-1:0]  rd_addr;
  logic                in_valid, in_ready;
  logic                out_valid, out_ready;
  iesrs_wr_t           in_word, out_word;
  logic                next_act;

  // two flip-flops on every level from outside the clock domain
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {vcc_ok_i, rf_mode_i, rf_write_busy_i, rf_cmd_busy_i, scl_i, sda_i};
      sync2 <= sync1;
    end
  end
  assign {vcc_s, mode_s, wr_busy_s, cmd_busy_s, scl_s, sda_s} = sync2;

  // previous levels for edge and condition detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // everything serial except start and stop advances only on master clock edges
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // start and stop: sda moves while scl stays high
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // select byte check, shifted in msb first
  assign dev_match = (shift_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE) &&
                     (shift_in[SEL_CE_BIT] == CHIP_EN) &&
                     (shift_in[2:1] == SEL_FIXED);

  // reads during a read burst fetch the byte after the pointer
  assign rd_addr = (state == IESRS_READ) ? addr + 1'b1 : addr;

  // sample data bits on scl rise, msb first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_in <= '0;
    end else if (scl_rise && bit_cnt != ACK_BIT) begin
      shift_in <= {shift_in[6:0], sda_s};
    end
  end

  // master acknowledge of each read byte
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      master_ack <= 1'h0;
    end else if (scl_rise && bit_cnt == ACK_BIT && state == IESRS_READ) begin
      master_ack <= ~sda_s;
    end
  end

  // written byte offered to the buffer at the end of its eighth bit
  assign in_valid = scl_fall && (bit_cnt == LAST_BIT) && (state == IESRS_WRITE);
  assign in_word  = '{addr: addr, data: shift_in};

  // serial protocol engine
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= IESRS_IDLE;
      bit_cnt  <= '0;
      addr     <= '0;
      rw       <= 1'h0;
      ack_drv  <= 1'h0;
      rd_shift <= 8'hFF;
    end else if (start_c) begin
      // start or repeated start always reopens the select byte
      state   <= IESRS_DEV;
      // one below bit 0: the scl fall that closes the start is not a data bit
      bit_cnt <= '1;
      ack_drv <= 1'h0;
    end else if (stop_c) begin
      state   <= IESRS_IDLE;
      bit_cnt <= '0;
      ack_drv <= 1'h0;
    end else if (scl_fall && state != IESRS_IDLE) begin
      if (bit_cnt != ACK_BIT) begin
        bit_cnt  <= bit_cnt + 1'b1;
        rd_shift <= {rd_shift[6:0], 1'h1};
        if (bit_cnt == LAST_BIT) begin
          case (state)
            IESRS_DEV: begin
              // acknowledge own select only, else drop off the bus
              ack_drv <= dev_match;
              rw      <= shift_in[SEL_RW_BIT];
              if (!dev_match) begin
                state <= IESRS_IDLE;
              end
            end
            IESRS_ADDR_HI: begin
              // high address byte first
              addr[BYTE_AW-1:8] <= shift_in[HI_ADDR_BITS-1:0];
              ack_drv           <= 1'h1;
            end
            IESRS_ADDR_LO: begin
              addr[7:0] <= shift_in;
              ack_drv   <= 1'h1;
            end
            IESRS_WRITE: begin
              // a full buffer refuses the byte with a no-acknowledge
              ack_drv <= in_ready;
              if (in_ready) begin
                addr <= addr + 1'b1;
              end
            end
            default: begin
              ack_drv <= 1'h0;                                      // read: master owns bit 9
            end
          endcase
        end
      end else begin
        // end of the ninth bit
        ack_drv <= 1'h0;
        bit_cnt <= '0;
        case (state)
          IESRS_DEV: begin
            if (rw) begin
              state    <= IESRS_READ;
              rd_shift <= mem[rd_addr];
            end else begin
              state <= IESRS_ADDR_HI;
            end
          end
          IESRS_ADDR_HI: state <= IESRS_ADDR_LO;
          IESRS_ADDR_LO: state <= IESRS_WRITE;
          IESRS_WRITE:   state <= IESRS_WRITE;
          IESRS_READ: begin
            // nack ends the burst, master then sends stop
            if (master_ack) begin
              addr     <= rd_addr;
              rd_shift <= mem[rd_addr];
            end else begin
              state <= IESRS_IDLE;
            end
          end
          default: state <= IESRS_IDLE;
        endcase
      end
    end
  end

  // sda is open drain: only ever pulled low
  assign sda_o    = 1'h0;
  assign sda_oe_o = ack_drv | ((state == IESRS_READ) && (bit_cnt != ACK_BIT) && !rd_shift[7]);

  // two-entry buffer; rf access to the array stalls its drain
  iesrs_buf #(
    .WIDTH ($bits(iesrs_wr_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .in_data_i   (in_word),
    .out_valid_o (out_valid),
    .out_ready_i (out_ready),
    .out_data_o  (out_word)
  );
  assign out_ready = ~(rf_req_i.rd | rf_req_i.wr);

  // array writes: rf word takes four bytes at once, else one queued serial byte
  always_ff @(posedge clk_i) begin
    if (rf_req_i.wr) begin
      for (int k = 0; k < WORD_BYTES; k++) begin
        mem[{rf_req_i.addr, k[1:0]}] <= rf_req_i.wdata[8*k +: 8];
      end
    end else if (out_valid) begin
      mem[out_word.addr] <= out_word.data;
    end
  end

  // rf word read, byte 0 in the low lane
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_rdata_o  <= '0;
      rf_rvalid_o <= 1'h0;
    end else begin
      rf_rvalid_o <= rf_req_i.rd;
      if (rf_req_i.rd) begin
        for (int k = 0; k < WORD_BYTES; k++) begin
          rf_rdata_o[8*k +: 8] <= mem[{rf_req_i.addr, k[1:0]}];
        end
      end
    end
  end

  // status pin: pick one indicator by mode, only with supply
  assign next_act = vcc_s && ((mode_s == IESRS_MODE_CMD) ? cmd_busy_s : wr_busy_s);

  // pin pulled low while active, released otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_activity_output_oe_o <= 1'h0;
    end else begin
      rf_activity_output_oe_o <= next_act;
    end
  end
  assign rf_activity_output_o = 1'h0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_rf_word_store: assert property (rf_req_i.wr ##1 (rf_req_i.rd && !rf_req_i.wr &&
      rf_req_i.addr == $past(rf_req_i.addr)) |=> rf_rdata_o == $past(rf_req_i.wdata, 2))
    else $error("rf word did not read back");
  chk_idle_silent: assert property (state == IESRS_IDLE && !$past(ack_drv) |-> !sda_oe_o)
    else $error("sda driven while idle");
  chk_select_ack: assert property (scl_fall && bit_cnt == LAST_BIT && state == IESRS_DEV && dev_match
      && !start_c |=> sda_oe_o && state == IESRS_DEV)
    else $error("matching select not acknowledged");
  chk_select_miss: assert property (scl_fall && bit_cnt == LAST_BIT && state == IESRS_DEV && !dev_match
      |=> state == IESRS_IDLE && !sda_oe_o)
    else $error("foreign select answered");
  chk_write_ack: assert property (scl_fall && bit_cnt == LAST_BIT && state == IESRS_WRITE && in_ready
      |=> ack_drv && bit_cnt == ACK_BIT)
    else $error("written byte not acknowledged");
  chk_ack_hold: assert property (ack_drv && !scl_fall && !start_c && !stop_c |=> ack_drv)
    else $error("ack dropped inside ninth bit");
  chk_ack_release: assert property (ack_drv && scl_fall && !start_c && !stop_c |=> !ack_drv)
    else $error("ack held past ninth bit");
  chk_wr_mode_pin: assert property (vcc_s && mode_s == IESRS_MODE_WRITE && wr_busy_s
      |=> rf_activity_output_oe_o && !rf_activity_output_o)
    else $error("write indicator not low");
  chk_cmd_mode_pin: assert property (vcc_s && mode_s == IESRS_MODE_CMD && cmd_busy_s
      |=> rf_activity_output_oe_o)
    else $error("command indicator not low");
  chk_pin_open_drain: assert property (rf_activity_output_o == 1'h0 && sda_o == 1'h0)
    else $error("open drain output driven high");
  chk_no_supply: assert property (!vcc_s |=> !rf_activity_output_oe_o)
    else $error("status pin active without supply");
  chk_pin_release: assert property (vcc_s && (mode_s == IESRS_MODE_CMD ? !cmd_busy_s : !wr_busy_s)
      |=> !rf_activity_output_oe_o)
    else $error("status pin not released");

  cov_select_ack: cover property (scl_fall && bit_cnt == LAST_BIT && state == IESRS_DEV && dev_match);
  cov_write_push: cover property (in_valid && in_ready);
  cov_write_refuse: cover property (in_valid && !in_ready);
  cov_read_burst: cover property (scl_fall && bit_cnt == ACK_BIT && state == IESRS_READ && master_ack);
  cov_pin_low: cover property (rf_activity_output_oe_o);

endmodule // iesrs_top

// ### verif/iesrs_master.sv
// Purpose: behavioural two-wire bus master facing the serial side of the slave
// Assumes: scl is push-pull from this model; sda is a pulled-up wired-and line
// Notes:   scl stands high between frames; one bit takes 160 ns, data moves mid low phase
module iesrs_master (
  input  wire logic sda_i,                                   // resolved data line
  output logic      scl_o,                                   // serial clock, idle high
  output logic      sda_oe_o                                 // high = master pulls data low
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int QTR = 40;                                   // quarter of a bit period

  // bus idle: both lines released
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // one bit out; entered and left with scl low, so data never moves while scl high
  task automatic bit_out(input logic b);
    #QTR sda_oe_o = ~b;
    #QTR scl_o = 1'b1;
    #(2*QTR) scl_o = 1'b0;
  endtask

  // one bit in; line released, sampled in the middle of the high phase
  task automatic bit_in(output logic b);
    #QTR sda_oe_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR b = sda_i;
    #QTR scl_o = 1'b0;
  endtask

  // start or repeated start: data falls while scl is high
  task automatic start();
    #QTR sda_oe_o = 1'b0;
    #QTR scl_o = 1'b1;
    #(2*QTR) sda_oe_o = 1'b1;
    #(2*QTR) scl_o = 1'b0;
  endtask

  // stop: data rises while scl is high, then the bus idles
  task automatic stop();
    #QTR sda_oe_o = 1'b1;
    #QTR scl_o = 1'b1;
    #(2*QTR) sda_oe_o = 1'b0;
    #(2*QTR);
  endtask

  // byte to the slave, msb first, then the slave's answer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_in(a);
    ack = ~a;
  endtask

  // byte from the slave; ack keeps the burst going, nack ends it
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(last);
  endtask
endmodule // iesrs_master

// ### verif/test_iesrs_top.sv
// Purpose: self-checking bench of the serial eeprom slave with rf status pin
// Assumes: bus master model drives scl and sda; rf port and status inputs driven here
// Notes:   shadow array tracks every byte written; unknown bytes are never read back
module test_iesrs_top;
  timeunit 1ns;
  timeprecision 100ps;
  import iesrs_pkg::*;

  localparam logic [3:0] DEV = 4'h5;                         // arbitrary device type code
  localparam logic       CEN = 1'h0;                         // chip enable value in use

  logic          clk, nrst, scl, sda, sda_o, sda_oe, m_sda_oe;
  logic          vcc_ok, rf_mode, wbusy, cbusy, act_o, act_oe, rvalid;
  logic [31:0]   rdata;                                      // rf read word
  iesrs_rf_req_t rf_req;                                     // rf word request
  logic [31:0]   seed;                                       // xorshift state
  logic [7:0]    exp_mem [MEM_BYTES];                        // expected array contents
  logic [7:0]    bad_sel [4];                                // refused select bytes
  logic          ack;
  logic [10:0]   a;
  int            error_cnt, checks_done;

  // wired-and data line with pull-up
  assign sda = !((sda_oe && !sda_o) || m_sda_oe);

  iesrs_top #(.DEV_TYPE(DEV), .CHIP_EN(CEN)) uut (
    .clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .vcc_ok_i(vcc_ok), .rf_mode_i(rf_mode), .rf_write_busy_i(wbusy), .rf_cmd_busy_i(cbusy),
    .rf_activity_output_o(act_o), .rf_activity_output_oe_o(act_oe),
    .rf_req_i(rf_req), .rf_rdata_o(rdata), .rf_rvalid_o(rvalid));

  iesrs_master m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_sda_oe));

  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // repeatable pseudo random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] sel(input logic rw);
    return {DEV, CEN, SEL_FIXED, rw};
  endfunction

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // select for write plus both address bytes
  task automatic set_ptr(input logic [10:0] p);
    m.start();
    m.wr_byte(sel(1'b0), ack);
    chk_bit("select ack", 1'b1, ack);
    m.wr_byte({5'h00, p[10:8]}, ack);
    chk_bit("addr hi ack", 1'b1, ack);
    m.wr_byte(p[7:0], ack);
    chk_bit("addr lo ack", 1'b1, ack);
  endtask

  // random bytes; the byte at index refuse must be refused, then the rf stall lifts
  task automatic ser_write(input logic [10:0] p, input int n, input int refuse);
    logic [7:0] d;
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      m.wr_byte(d, ack);
      chk_bit("data ack", i != refuse, ack);
      if (i == refuse) begin
        @(posedge clk) #1 rf_req.rd = 1'b0;
        repeat (4) @(posedge clk);
        // keep the master's steps off the sampling edge
        #1;
      end else begin
        exp_mem[p] = d;
        p++;
      end
    end
    m.stop();
  endtask

  // random read through a repeated start
  task automatic ser_read(input logic [10:0] p, input int n);
    logic [7:0] d;
    set_ptr(p);
    m.start();
    m.wr_byte(sel(1'b1), ack);
    chk_bit("read select ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      m.rd_byte(i == n - 1, d);
      chk_val("read byte", {24'h0, exp_mem[11'(p + i)]}, {24'h0, d});
    end
    m.stop();
  endtask

  // write stays raised; the rf_read that follows lowers it, so the read back comes at once
  task automatic rf_write(input logic [8:0] w, input logic [31:0] v);
    @(posedge clk) #1;
    rf_req.wr = 1'b1;
    rf_req.addr = w;
    rf_req.wdata = v;
    for (int k = 0; k < 4; k++) begin
      exp_mem[{w, 2'(k)}] = v[8*k +: 8];
    end
  endtask

  // answer one cycle after the request, then a single-cycle pulse
  task automatic rf_read(input logic [8:0] w);
    @(posedge clk) #1;
    rf_req.wr = 1'b0;
    rf_req.rd = 1'b1;
    rf_req.addr = w;
    @(posedge clk) #1;
    rf_req.rd = 1'b0;
    chk_bit("rf rvalid", 1'b1, rvalid);
    chk_val("rf word", {exp_mem[{w, 2'h3}], exp_mem[{w, 2'h2}], exp_mem[{w, 2'h1}], exp_mem[{w, 2'h0}]}, rdata);
    @(posedge clk) #1;
    chk_bit("rf rvalid end", 1'b0, rvalid);
  endtask

  // watchdog, well beyond the expected run of some 130 us
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    {nrst, vcc_ok, rf_mode, wbusy, cbusy} = 5'h00;
    rf_req = '0;
    seed = 32'h43;
    error_cnt = 0;
    checks_done = 0;
    bad_sel = '{{DEV ^ 4'h1, CEN, SEL_FIXED, 1'b0}, {DEV, ~CEN, SEL_FIXED, 1'b0},
                {DEV, CEN, 2'h2, 1'b0}, {DEV, CEN, 2'h1, 1'b0}};
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    chk_bit("sda drive in reset", 1'b0, sda_oe);
    chk_bit("status in reset", 1'b0, act_oe);
    chk_bit("rvalid in reset", 1'b0, rvalid);
    // every supply, mode and busy combination on the status pin
    for (int c = 0; c < 16; c++) begin
      @(posedge clk) #1;
      {vcc_ok, rf_mode, wbusy, cbusy} = 4'(c);
      repeat (4) @(posedge clk);
      #1;
      chk_bit("status pull", vcc_ok & (rf_mode ? cbusy : wbusy), act_oe);
      chk_bit("status level", 1'b0, act_o);
    end
    vcc_ok = 1'b1;
    // burst across the top of the array, then both views of it
    ser_write(11'h7FC, 6, -1);
    ser_read(11'h7FC, 6);
    rf_read(9'h1FF);
    rf_write(9'h005, rnd());
    rf_read(9'h005);
    ser_read(11'h014, 4);
    // refused select bytes get no acknowledge
    foreach (bad_sel[i]) begin
      m.start();
      m.wr_byte(bad_sel[i], ack);
      chk_bit("bad select ack", 1'b0, ack);
      m.stop();
    end
    // rf reads held back to back stall the buffer until the third byte is refused
    @(posedge clk) #1 rf_req.rd = 1'b1;
    ser_write(11'h100, 4, 2);
    ser_read(11'h100, 3);
    // random places and contents
    repeat (3) begin
      a = 11'(rnd());
      ser_write(a, 3, -1);
      ser_read(a, 3);
    end
    close_out();
  end
endmodule // test_iesrs_top
